// ---- rtl/byte_add_logic_bit_alu.sv ----
// Execution slice for add-with-carry, add, AND and bit-AND on a register file
//
// Summary of operation
// - Add-with-carry adds carry into destination
// - Plain add ignores carry, source untouched
// - Carry flag from bit 7 carry-out
// - Zero and sign flags follow sum
// - Overflow when like signs give unlike sign
// - Half-carry from bit 3 into nibble
// - Additions always clear decimal-adjust flag
// - AND stores bitwise conjunction in destination
// - AND sets zero and copies bit 7
// - AND clears overflow, keeps C, D, H
// - Bit-AND into bit 0 or indexed bit
// - Bit-AND changes only the target bit
// - Bit-AND sets zero, clears sign, keeps carry
// - Second byte: register, bit index, form select
// - Flags written to register D5h
`include "byte_alu_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module byte_add_logic_bit_alu (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Instruction from the decoder
    input  wire logic       start,
    input  wire logic [7:0] opcode,
    input  wire logic [7:0] byte2,
    input  wire logic [7:0] byte3,
    input  wire logic [3:0] work_base,
    // Register file access, honoured only while idle
    input  wire logic [7:0] host_addr,
    input  wire logic       host_we,
    input  wire logic [7:0] host_wdata,
    output logic      [7:0] host_rdata,
    // Status
    output logic            busy,
    output logic            done,
    output logic            illegal,
    output logic      [7:0] result,
    output logic      [7:0] flags
);

    byte_alu_pkg::state_e state_reg;
    byte_alu_pkg::dec_s   dec_reg;
    byte_alu_pkg::dec_s   dec_in;
    logic [7:0]           src_val_reg;
    logic [7:0]           dst_val_reg;
    logic [7:0]           result_reg;
    logic [7:0]           flags_reg;
    logic                 done_reg;
    logic                 illegal_reg;
    logic                 phase_reg;
    logic [3:0]           cyc_reg;
    logic                 cyc_tick;
    logic [3:0]           cyc_len;
    logic [7:0]           mem_addr;
    logic                 mem_we;
    logic [7:0]           mem_wdata;
    logic [7:0]           mem_rdata;
    logic [7:0]           result_next;
    logic [7:0]           flags_next;
    logic                 cin;
    logic [8:0]           sum9;
    logic [4:0]           half5;
    logic [7:0]           bit_mask;

    // Decode one instruction into operand addresses and form
    function automatic byte_alu_pkg::dec_s decode(input logic [7:0] op,
        input logic [7:0] b2, input logic [7:0] b3, input logic [3:0] wb);
        byte_alu_pkg::dec_s d;
        d = '0;
        d.kind = byte_alu_pkg::K_ADD;
        d.valid = (op[3:0] >= `OP_LO_RR) && (op[3:0] <= `OP_LO_IMM);
        case (op[7:4])
            `OP_HI_ADC: d.kind = byte_alu_pkg::K_ADC;
            `OP_HI_ADD: d.kind = byte_alu_pkg::K_ADD;
            `OP_HI_AND: d.kind = byte_alu_pkg::K_AND;
            default:    d.valid = 1'b0;
        endcase
        case (op[3:0])
            `OP_LO_RR:  {d.dst, d.src, d.short_form} = {wb, b2[7:4], wb, b2[3:0], 1'b1};
            `OP_LO_RIR: {d.dst, d.src, d.ind} = {wb, b2[7:4], wb, b2[3:0], 1'b1};
            `OP_LO_REG: {d.dst, d.src} = {b3, b2};
            `OP_LO_IND: {d.dst, d.src, d.ind} = {b3, b2, 1'b1};
            `OP_LO_IMM: {d.dst, d.src, d.imm} = {b2, b3, 1'b1};
            default:    d.dst = 8'h00;
        endcase
        // bit-AND byte fields and form selector
        if (op == `OP_BAND)
        begin
            d = '0;
            d.valid = 1'b1;
            d.kind = byte_alu_pkg::K_BAND;
            d.bit_sel = b2[0];
            d.bit_idx = b2[3:1];
            d.dst = b2[0] ? b3 : {wb, b2[7:4]};
            d.src = b2[0] ? {wb, b2[7:4]} : b3;
        end
        return d;
    endfunction

    assign dec_in  = decode(opcode, byte2, byte3, work_base);
    assign cyc_len = dec_reg.short_form ? `CYC_SHORT : `CYC_LONG;

    // Register file; host reaches it only between instructions
    reg_mem u_mem (
        .clk   (clk),
        .addr  (mem_addr),
        .we    (mem_we),
        .wdata (mem_wdata),
        .rdata (mem_rdata)
    );

    // Address and write mux driven by the sequencer
    always_comb
    begin
        mem_addr  = host_addr;
        mem_we    = 1'b0;
        mem_wdata = host_wdata;
        case (state_reg)
            byte_alu_pkg::S_IDLE: mem_we = host_we;
            byte_alu_pkg::S_PTR:  mem_addr = dec_reg.src;
            // pointer contents address the real operand
            byte_alu_pkg::S_SRC:  mem_addr = dec_reg.ind ? mem_rdata : dec_reg.src;
            byte_alu_pkg::S_DST:  mem_addr = dec_reg.dst;
            byte_alu_pkg::S_FLG:  mem_addr = `FLAGS_ADDR;
            byte_alu_pkg::S_WR:
            begin
                mem_addr  = dec_reg.dst;
                mem_we    = 1'b1;
                mem_wdata = result_reg;
            end
            // flags go back to their register
            byte_alu_pkg::S_FW:
            begin
                mem_addr  = `FLAGS_ADDR;
                mem_we    = 1'b1;
                mem_wdata = flags_reg;
            end
            default:              mem_addr = host_addr;
        endcase
    end

    // Sequencer: one register file access per clock
    always_ff @(posedge clk)
    begin
        if (reset)
            state_reg <= byte_alu_pkg::S_IDLE;
        else
            case (state_reg)
                byte_alu_pkg::S_IDLE:
                    if (start && dec_in.valid)
                        state_reg <= dec_in.ind ? byte_alu_pkg::S_PTR :
                                     dec_in.imm ? byte_alu_pkg::S_DST :
                                                  byte_alu_pkg::S_SRC;
                byte_alu_pkg::S_PTR:  state_reg <= byte_alu_pkg::S_SRC;
                byte_alu_pkg::S_SRC:  state_reg <= byte_alu_pkg::S_DST;
                byte_alu_pkg::S_DST:  state_reg <= byte_alu_pkg::S_FLG;
                byte_alu_pkg::S_FLG:  state_reg <= byte_alu_pkg::S_CAP;
                byte_alu_pkg::S_CAP:  state_reg <= byte_alu_pkg::S_WR;
                byte_alu_pkg::S_WR:   state_reg <= byte_alu_pkg::S_FW;
                byte_alu_pkg::S_FW:   state_reg <= byte_alu_pkg::S_WAIT;
                byte_alu_pkg::S_WAIT:
                    if (cyc_tick && cyc_reg == cyc_len - 4'h1)
                        state_reg <= byte_alu_pkg::S_IDLE;
                default:              state_reg <= byte_alu_pkg::S_IDLE;
            endcase
    end

    // Instruction latch; decoder inputs may change after start
    always_ff @(posedge clk)
    begin
        if (reset)
            dec_reg <= '0;
        else if (state_reg == byte_alu_pkg::S_IDLE && start)
            dec_reg <= dec_in;
    end

    // Operand capture; immediates come from the instruction bytes
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            src_val_reg <= 8'h00;
            dst_val_reg <= 8'h00;
        end
        else if (state_reg == byte_alu_pkg::S_DST)
            src_val_reg <= dec_reg.imm ? dec_reg.src : mem_rdata;
        else if (state_reg == byte_alu_pkg::S_FLG)
            dst_val_reg <= mem_rdata;
    end

    // Arithmetic and logic; mem_rdata holds the old flags in S_CAP
    always_comb
    begin
        cin         = (dec_reg.kind == byte_alu_pkg::K_ADC) && mem_rdata[`FLAG_C];
        sum9        = {1'b0, dst_val_reg} + {1'b0, src_val_reg} + {8'h00, cin};
        half5       = {1'b0, dst_val_reg[3:0]} + {1'b0, src_val_reg[3:0]}
                      + {4'h0, cin};
        bit_mask    = 8'h01 << dec_reg.bit_idx;
        flags_next  = mem_rdata;
        result_next = dst_val_reg;
        case (dec_reg.kind)
            byte_alu_pkg::K_ADC, byte_alu_pkg::K_ADD:
            begin
                // two's-complement sum, carry in for ADC only
                result_next            = sum9[7:0];
                flags_next[`FLAG_C]    = sum9[8];
                flags_next[`FLAG_Z]    = (sum9[7:0] == 8'h00);
                flags_next[`FLAG_S]    = sum9[7];
                flags_next[`FLAG_V]    = (dst_val_reg[7] == src_val_reg[7])
                                         && (sum9[7] != dst_val_reg[7]);
                flags_next[`FLAG_D]    = 1'b0;
                // carry out of the low nibble
                flags_next[`FLAG_H]    = half5[4];
            end
            byte_alu_pkg::K_AND:
            begin
                result_next            = dst_val_reg & src_val_reg;
                flags_next[`FLAG_Z]    = ((dst_val_reg & src_val_reg) == 8'h00);
                flags_next[`FLAG_S]    = dst_val_reg[7] & src_val_reg[7];
                // overflow cleared, C D H kept
                flags_next[`FLAG_V]    = 1'b0;
            end
            default:
            begin
                // only the one target bit may change
                if (dec_reg.bit_sel)
                begin
                    result_next[dec_reg.bit_idx] = dst_val_reg[dec_reg.bit_idx]
                                                   & src_val_reg[0];
                    flags_next[`FLAG_Z] = ~result_next[dec_reg.bit_idx];
                end
                else
                begin
                    result_next[0] = dst_val_reg[0]
                                     & |(src_val_reg & bit_mask);
                    flags_next[`FLAG_Z] = ~result_next[0];
                end
                // sign cleared; C, V, D, H left as they were
                flags_next[`FLAG_S] = 1'b0;
            end
        endcase
    end

    // Result and flags held for the write-back and for the outputs
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            result_reg <= 8'h00;
            flags_reg  <= 8'h00;
        end
        else if (state_reg == byte_alu_pkg::S_CAP)
        begin
            result_reg <= result_next;
            flags_reg  <= flags_next;
        end
    end

    assign cyc_tick = (phase_reg == `CLKS_PER_CYC);
    always_ff @(posedge clk)
    begin
        if (reset || state_reg == byte_alu_pkg::S_IDLE)
        begin
            phase_reg <= 1'b0;
            cyc_reg   <= 4'h0;
        end
        else
        begin
            phase_reg <= cyc_tick ? 1'b0 : phase_reg + 1'b1;
            if (cyc_tick)
                cyc_reg <= cyc_reg + 4'h1;
        end
    end

    // Completion and refusal pulses
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            done_reg    <= 1'b0;
            illegal_reg <= 1'b0;
        end
        else
        begin
            done_reg    <= state_reg == byte_alu_pkg::S_WAIT && cyc_tick
                           && cyc_reg == cyc_len - 4'h1;
            illegal_reg <= state_reg == byte_alu_pkg::S_IDLE && start
                           && !dec_in.valid;
        end
    end

    assign busy       = (state_reg != byte_alu_pkg::S_IDLE);
    assign done       = done_reg;
    assign illegal    = illegal_reg;
    assign result     = result_reg;
    assign flags      = flags_reg;
    assign host_rdata = mem_rdata;

    // done flop rises on the 8th edge after the taking edge
    // so it is first sampled high one edge later
    a_short_timing: assert property (@(posedge clk) disable iff (reset)
        (state_reg == byte_alu_pkg::S_IDLE && start && dec_in.valid
         && dec_in.short_form) |-> ##9 done)
        else $error("short form did not finish in 4 cycles");

    // long forms raise done on the 12th edge; quiet until then
    a_long_timing: assert property (@(posedge clk) disable iff (reset)
        (state_reg == byte_alu_pkg::S_IDLE && start && dec_in.valid
         && !dec_in.short_form)
        |-> ##1 !done [*8] ##1 !done [*4] ##1 done)
        else $error("long form did not finish in 6 cycles");

    a_adc_result: assert property (@(posedge clk) disable iff (reset)
        (state_reg == byte_alu_pkg::S_CAP
         && dec_reg.kind == byte_alu_pkg::K_ADC) |=>
        result_reg == 8'($past(dst_val_reg) + $past(src_val_reg)
                         + {7'h00, $past(mem_rdata[`FLAG_C])}))
        else $error("add-with-carry result wrong");

    // carry flag set exactly on unsigned wrap
    a_carry_flag: assert property (@(posedge clk) disable iff (reset)
        (state_reg == byte_alu_pkg::S_CAP
         && dec_reg.kind == byte_alu_pkg::K_ADD) |=>
        flags_reg[`FLAG_C] == (result_reg < $past(dst_val_reg)))
        else $error("carry flag wrong after add");

    // zero, sign and decimal-adjust after additions
    a_add_zsd: assert property (@(posedge clk) disable iff (reset)
        (state_reg == byte_alu_pkg::S_CAP
         && (dec_reg.kind == byte_alu_pkg::K_ADD
             || dec_reg.kind == byte_alu_pkg::K_ADC)) |=>
        flags_reg[`FLAG_Z] == (result_reg == 8'h00)
        && flags_reg[`FLAG_S] == result_reg[7] && !flags_reg[`FLAG_D])
        else $error("zero, sign or decimal flag wrong after add");

    // AND keeps carry, decimal and half-carry, clears overflow
    a_and_keep: assert property (@(posedge clk) disable iff (reset)
        (state_reg == byte_alu_pkg::S_CAP
         && dec_reg.kind == byte_alu_pkg::K_AND) |=>
        !flags_reg[`FLAG_V] && flags_reg[`FLAG_C] == $past(mem_rdata[`FLAG_C])
        && flags_reg[`FLAG_H] == $past(mem_rdata[`FLAG_H])
        && flags_reg[`FLAG_D] == $past(mem_rdata[`FLAG_D]))
        else $error("AND disturbed kept flags");

    // bit-AND changes nothing outside the target bit
    a_band_bits: assert property (@(posedge clk) disable iff (reset)
        (state_reg == byte_alu_pkg::S_CAP
         && dec_reg.kind == byte_alu_pkg::K_BAND) |=>
        ((result_reg ^ $past(dst_val_reg))
         & ~(dec_reg.bit_sel ? bit_mask : 8'h01)) == 8'h00
        && !flags_reg[`FLAG_S])
        else $error("bit-AND touched other bits");

    // result then flags written back in consecutive clocks
    a_flags_write: assert property (@(posedge clk) disable iff (reset)
        (state_reg == byte_alu_pkg::S_WR) |-> mem_we && mem_wdata == result_reg
        ##1 mem_we && mem_addr == `FLAGS_ADDR && mem_wdata == flags_reg)
        else $error("write-back order wrong");

endmodule
`default_nettype wire

// ---- rtl/byte_alu_cfg.svh ----
// Constants for the byte add, logic and bit-AND execution slice
`ifndef BYTE_ALU_CFG_SVH
`define BYTE_ALU_CFG_SVH

// Register file location of the condition flags
`define FLAGS_ADDR     8'hD5

// Bit positions inside the flags register
`define FLAG_C         7
`define FLAG_Z         6
`define FLAG_S         5
`define FLAG_V         4
`define FLAG_D         3
`define FLAG_H         2

// Opcode upper nibbles and lower-nibble addressing forms
`define OP_HI_ADD      4'h0
`define OP_HI_ADC      4'h1
`define OP_HI_AND      4'h5
`define OP_LO_RR       4'h2
`define OP_LO_RIR      4'h3
`define OP_LO_REG      4'h4
`define OP_LO_IND      4'h5
`define OP_LO_IMM      4'h6
`define OP_BAND        8'h67

// Instruction lengths in instruction cycles, and the last clock phase of a two-clock cycle
`define CYC_SHORT      4'h4
`define CYC_LONG       4'h6
`define CLKS_PER_CYC   1'h1

`endif

// ---- rtl/byte_alu_pkg.sv ----
// Types shared by the byte add, logic and bit-AND execution slice
`default_nettype none
package byte_alu_pkg;

    // Sequencer states
    typedef enum logic [3:0]
    {
        S_IDLE = 4'h0,
        S_PTR  = 4'h1,
        S_SRC  = 4'h2,
        S_DST  = 4'h3,
        S_FLG  = 4'h4,
        S_CAP  = 4'h5,
        S_WR   = 4'h6,
        S_FW   = 4'h7,
        S_WAIT = 4'h8
    } state_e;

    // Operation kinds
    typedef enum logic [1:0]
    {
        K_ADC  = 2'h0,
        K_ADD  = 2'h1,
        K_AND  = 2'h2,
        K_BAND = 2'h3
    } kind_e;

    // Decoded instruction
    typedef struct packed
    {
        logic       valid;
        kind_e      kind;
        logic       ind;
        logic       imm;
        logic       short_form;
        logic       bit_sel;
        logic [2:0] bit_idx;
        logic [7:0] dst;
        logic [7:0] src;
    } dec_s;

endpackage
`default_nettype wire

// ---- rtl/reg_mem.sv ----
// Single-port 256 x 8 register file with registered read data
`timescale 1ns/100ps
`default_nettype none
module reg_mem (
    // Clock
    input  wire logic       clk,
    // Access port
    input  wire logic [7:0] addr,
    input  wire logic       we,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata
);

    logic [7:0] mem [0:255];

    // Contents are not reset; software initialises what it uses
    always_ff @(posedge clk)
    begin
        if (we)
            mem[addr] <= wdata;
    end

    // Read data registered, one clock after the address
    always_ff @(posedge clk)
    begin
        rdata <= mem[addr];
    end

endmodule
`default_nettype wire

// ---- tb/byte_add_logic_bit_alu_tb_top.sv ----
// Self-checking bench for the byte add, logic and bit-AND slice
`include "byte_alu_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module byte_add_logic_bit_alu_tb_top;
    // Row: opcode, byte2, byte3, dest, source, flags in, result, flags, clocks
    typedef struct packed
    {
        logic [7:0] op, b2, b3, dv, sv, fin, res, flg, cyc;
    } row_s;

    logic       clk        = 1'b0;
    logic       reset      = 1'b1;
    logic       go         = 1'b0;
    logic [7:0] op_in      = 8'h00;
    logic [7:0] b2_in      = 8'h00;
    logic [7:0] b3_in      = 8'h00;
    logic [3:0] work_base  = 4'h1;
    logic [7:0] host_addr  = 8'h00;
    logic       host_we    = 1'b0;
    logic [7:0] host_wdata = 8'h00;
    logic       start, busy, done, illegal;
    logic [7:0] opcode, byte2, byte3, lat, host_rdata, result, flags;
    int         err_count       = 0;
    int         samples_checked = 0;
    row_s       rows [18] = '{
        72'h12_12_00_10_03_80_14_00_08, 72'h13_12_00_10_0A_83_1B_03_0C,
        72'h14_21_20_FF_00_80_00_C4_0C, 72'h15_21_20_7F_01_00_80_34_0C,
        72'h16_20_11_20_11_88_32_00_0C, 72'h02_12_00_12_03_8C_15_00_08,
        72'h03_12_00_80_80_00_00_D0_0C, 72'h04_21_20_0F_01_01_10_05_0C,
        72'h05_21_20_21_0A_00_2B_00_0C, 72'h06_20_25_21_25_00_46_00_0C,
        72'h52_12_00_12_03_9C_02_8C_08, 72'h53_12_00_F0_0F_10_00_40_0C,
        72'h54_21_20_81_80_6C_80_2C_0C, 72'h55_21_20_21_03_00_01_00_0C,
        72'h56_20_25_21_25_00_21_00_0C, 72'h67_12_20_07_05_3C_06_5C_0C,
        72'h67_13_20_07_01_A0_07_80_0C, 72'h67_1E_20_01_80_40_01_00_0C};
    logic [7:0] bad [4] = '{8'h01, 8'h07, 8'h57, 8'h77};
    logic [7:0] v;

    // 40 MHz core clock
    always #12.5 clk = ~clk;

    issue_model issuer (.clk(clk), .reset(reset), .go(go), .op_in(op_in),
        .b2_in(b2_in), .b3_in(b3_in), .busy(busy), .done(done),
        .start(start), .opcode(opcode), .byte2(byte2), .byte3(byte3),
        .lat(lat));

    byte_add_logic_bit_alu DUT (.clk(clk), .reset(reset), .start(start),
        .opcode(opcode), .byte2(byte2), .byte3(byte3),
        .work_base(work_base), .host_addr(host_addr), .host_we(host_we),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .busy(busy),
        .done(done), .illegal(illegal), .result(result), .flags(flags));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task end_of_test;
        if (err_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Host port only works while idle, one write per clock
    task automatic hw(input logic [7:0] a, d);
        @(posedge clk);
        host_addr  <= a;
        host_wdata <= d;
        host_we    <= 1'b1;
        @(posedge clk);
        host_we    <= 1'b0;
    endtask

    task automatic hr(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        host_addr <= a;
        @(posedge clk);
        #1;
        d = host_rdata;
    endtask

    // Bounded wait; a hang ends the run
    task automatic wait_done;
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (done !== 1'b1 && illegal !== 1'b1 && n < 60);
        if (n >= 60)
        begin
            chk("done", {7'h00, done}, 8'h01);
            end_of_test;
        end
    endtask

    task automatic issue(input logic [7:0] op, b2, b3);
        @(posedge clk);
        go    <= 1'b1;
        op_in <= op;
        b2_in <= b2;
        b3_in <= b3;
        @(posedge clk);
        go    <= 1'b0;
        wait_done;
    endtask

    // Operand places follow the addressing form of the opcode
    task automatic run(input row_s r);
        logic [7:0] da, sa, pa;
        logic       ind, imm;
        ind = (r.op[3:0] == 4'h3 || r.op[3:0] == 4'h5);
        imm = (r.op[3:0] == 4'h6);
        pa  = 8'h00;
        if (r.op == 8'h67)
        begin
            da = r.b2[0] ? r.b3 : {work_base, r.b2[7:4]};
            sa = r.b2[0] ? {work_base, r.b2[7:4]} : r.b3;
        end
        else if (r.op[3:0] < 4'h4)
        begin
            da = {work_base, r.b2[7:4]};
            sa = {work_base, r.b2[3:0]};
        end
        else
        begin
            da = imm ? r.b2 : r.b3;
            sa = r.b2;
        end
        if (ind)
        begin
            pa = sa;
            sa = 8'h40;
            hw(pa, 8'h40);
        end
        hw(da, r.dv);
        if (!imm)
            hw(sa, r.sv);
        hw(`FLAGS_ADDR, r.fin);
        issue(r.op, r.b2, r.b3);
        chk("result", result, r.res);
        chk("flags", flags, r.flg);
        @(posedge clk);
        #1;
        chk("latency", lat, r.cyc);
        hr(da, v);
        chk("dest reg", v, r.res);
        if (!imm)
        begin
            hr(sa, v);
            chk("source reg", v, r.sv);
        end
        hr(`FLAGS_ADDR, v);
        chk("flag reg", v, r.flg);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        chk("busy", {7'h00, busy}, 8'h00);
        chk("done", {7'h00, done | illegal}, 8'h00);
        chk("result", result, 8'h00);
        chk("flags", flags, 8'h00);
        foreach (rows[i])
            run(rows[i]);
        // Unsupported opcodes change nothing
        foreach (bad[i])
        begin
            hw(8'h11, 8'h5A);
            issue(bad[i], 8'h12, 8'h00);
            chk("illegal", {7'h00, illegal}, 8'h01);
            hr(8'h11, v);
            chk("kept reg", v, 8'h5A);
        end
        // Second request held during busy, host write while busy
        hw(8'h11, 8'h12);
        hw(8'h12, 8'h03);
        hw(`FLAGS_ADDR, 8'h00);
        hw(8'h70, 8'h55);
        issue(8'h02, 8'h12, 8'h00);
        chk("result", result, 8'h15);
        // Result stands while no instruction runs
        repeat (3) @(posedge clk);
        #1;
        chk("result", result, 8'h15);
        @(posedge clk);
        go    <= 1'b1;
        op_in <= 8'h02;
        @(posedge clk);
        go    <= 1'b0;
        @(posedge clk);
        go         <= 1'b1;
        op_in      <= 8'h52;
        host_addr  <= 8'h70;
        host_wdata <= 8'hAA;
        host_we    <= 1'b1;
        @(posedge clk);
        go      <= 1'b0;
        host_we <= 1'b0;
        wait_done;
        chk("first result", result, 8'h18);
        wait_done;
        chk("second result", result, 8'h00);
        @(posedge clk);
        #1;
        chk("latency", lat, 8'h08);
        hr(8'h70, v);
        chk("busy write", v, 8'h55);
        // Reset in mid-instruction
        @(posedge clk);
        go    <= 1'b1;
        op_in <= 8'h04;
        @(posedge clk);
        go    <= 1'b0;
        repeat (4) @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk("busy", {7'h00, busy}, 8'h00);
        chk("result", result, 8'h00);
        chk("flags", flags, 8'h00);
        end_of_test;
    end
endmodule
`default_nettype wire

// ---- tb/issue_model.sv ----
// Instruction issuer standing in for the core's decoder and sequencer
`timescale 1ns/100ps
`default_nettype none
module issue_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Requests from the bench
    input  wire logic       go,
    input  wire logic [7:0] op_in,
    input  wire logic [7:0] b2_in,
    input  wire logic [7:0] b3_in,
    // Instruction port of the slice
    input  wire logic       busy,
    input  wire logic       done,
    output logic            start  = 1'b0,
    output logic      [7:0] opcode = 8'h00,
    output logic      [7:0] byte2  = 8'h00,
    output logic      [7:0] byte3  = 8'h00,
    // Clocks from the taking edge to done
    output logic      [7:0] lat    = 8'h00
);
    logic [7:0] cnt_reg = 8'h00;

    // --------------------------------------------------------------
    // Request hold and release
    // --------------------------------------------------------------
    // Held until taken; bytes then flip so a late re-read cannot pass
    always @(posedge clk)
    begin
        if (reset)
        begin
            start <= 1'b0;
        end
        else if (start && !busy)
        begin
            start  <= 1'b0;
            opcode <= ~opcode;
            byte2  <= ~byte2;
            byte3  <= ~byte3;
        end
        else if (go)
        begin
            start  <= 1'b1;
            opcode <= op_in;
            byte2  <= b2_in;
            byte3  <= b3_in;
        end
    end

    // Latency count, restarted at each taking edge
    always @(posedge clk)
    begin
        cnt_reg <= (start && !busy) ? 8'h00 : cnt_reg + 8'h01;
        if (done)
        begin
            lat <= cnt_reg;
        end
    end
endmodule
`default_nettype wire
